// ==== src/clock_source_output_control_regs.vh ====
`ifndef CLOCK_SOURCE_OUTPUT_CONTROL_REGS_VH
`define CLOCK_SOURCE_OUTPUT_CONTROL_REGS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define CTRL_ONE_ADDR 8'h00
`define CTRL_TWO_ADDR 8'h04
`define TRIM_ADDR 8'h08
`define STATUS_ADDR 8'h0C

// ----------------------------------------------------------------
// Control one fields
// ----------------------------------------------------------------
`define C1_CLKSRC_HI 7
`define C1_CLKSRC_LO 6
`define C1_REF_DIVIDER_SEL_HI 5
`define C1_REF_DIVIDER_SEL_LO 3
`define C1_IREF_SEL 2
`define C1_IREF_OUT 1
`define C1_IREF_STOP 0

// ----------------------------------------------------------------
// Control two fields
// ----------------------------------------------------------------
`define C2_BUS_DIVIDER_SEL_HI 7
`define C2_BUS_DIVIDER_SEL_LO 6
`define C2_LP 3
`define C2_EXT_OSC 2
`define C2_EREF_OUT 1
`define C2_EREF_STOP 0

// ----------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------
`define SC_MODE_HI 3
`define SC_MODE_LO 2
`define SC_OSC_INIT 1
`define SC_FINE_TRIM_BIT 0

// ----------------------------------------------------------------
// Reset values and modes
// ----------------------------------------------------------------
`define CTRL_ONE_RST 8'h04
`define CTRL_TWO_RST 8'h40
`define TRIM_POWERUP 8'h80
`define MODE_FLL 2'h0
`define MODE_INT 2'h1
`define MODE_EXT 2'h2
`define MODE_RSVD 2'h3

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 10
`define IRC_SETTLE_NS 1000
`define IRC_SETTLE_CYC ((`IRC_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define IRC_BASE_HALF 10'h040
`define SWITCH_TICKS 3'h3
`define FLL_LOCK_REFS 4'h8
`define FFE_OFFSET 3'h2

`endif

// ==== src/clock_source_output_control.v ====
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "clock_source_output_control_regs.vh"

module clock_source_output_control #(
  parameter OSC_INIT_EDGES = 4096
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // Register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // System inputs
  input wire stop_mode,
  input wire ext_ref_in,
  // Clock outputs
  output reg main_clock_out,
  output reg int_ref_clock_out,
  output reg ext_ref_clock_out,
  output reg fixed_freq_clock,
  output wire fixed_freq_valid,
  output wire fll_enable,
  output reg fll_locked
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [7:0] ctrl_one_ff;
  reg [7:0] ctrl_two_ff;
  reg [7:0] coarse_trim_register = `TRIM_POWERUP;
  reg fine_trim_bit = 1'b0;
  reg [1:0] clock_mode_status;
  reg osc_init_done;

  wire [1:0] clock_source_select = ctrl_one_ff[`C1_CLKSRC_HI:`C1_CLKSRC_LO];
  wire [2:0] ref_divider_sel = ctrl_one_ff[`C1_REF_DIVIDER_SEL_HI:`C1_REF_DIVIDER_SEL_LO];
  wire int_ref_select = ctrl_one_ff[`C1_IREF_SEL];
  wire int_ref_out_enable = ctrl_one_ff[`C1_IREF_OUT];
  wire int_ref_stop_enable = ctrl_one_ff[`C1_IREF_STOP];
  wire [1:0] bus_divider_sel = ctrl_two_ff[`C2_BUS_DIVIDER_SEL_HI:`C2_BUS_DIVIDER_SEL_LO];
  wire fll_power_saver_bit = ctrl_two_ff[`C2_LP];
  wire ext_osc_select = ctrl_two_ff[`C2_EXT_OSC];
  wire ext_ref_out_enable = ctrl_two_ff[`C2_EREF_OUT];
  wire ext_ref_stop_enable = ctrl_two_ff[`C2_EREF_STOP];

  // ----------------------------------------------------------------
  // Register write decode
  // ----------------------------------------------------------------
  wire wr_one = reg_wr && (reg_addr == `CTRL_ONE_ADDR);
  wire wr_two = reg_wr && (reg_addr == `CTRL_TWO_ADDR);
  wire wr_trim = reg_wr && (reg_addr == `TRIM_ADDR);
  wire wr_stat = reg_wr && (reg_addr == `STATUS_ADDR);

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_one_ff <= `CTRL_ONE_RST;
      ctrl_two_ff <= `CTRL_TWO_RST;
    end else begin
      if (wr_one) begin
        ctrl_one_ff <= reg_wdata;
      end
      if (wr_two) begin
        ctrl_two_ff <= {reg_wdata[7:6], 2'h0, reg_wdata[3:0]};
      end
    end
  end

  // Trim holds across reset
  always @(posedge sys_clk) begin
    if (wr_trim) begin
      coarse_trim_register <= reg_wdata;
    end
    if (wr_stat) begin
      fine_trim_bit <= reg_wdata[`SC_FINE_TRIM_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `CTRL_ONE_ADDR: reg_rdata <= ctrl_one_ff;
        `CTRL_TWO_ADDR: reg_rdata <= ctrl_two_ff;
        `TRIM_ADDR: reg_rdata <= coarse_trim_register;
        `STATUS_ADDR: reg_rdata <= {4'h0, clock_mode_status,
                                    osc_init_done, fine_trim_bit};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Internal reference
  // ----------------------------------------------------------------
  reg [9:0] irc_cnt_ff;
  reg irc_ff;
  reg [15:0] irc_settle_ff;
  reg irc_stable_ff;
  wire [9:0] irc_half = `IRC_BASE_HALF + {2'h0, coarse_trim_register}
                        + {9'h000, fine_trim_bit};
  wire int_needed = int_ref_select || int_ref_out_enable
                    || (clock_source_select == `MODE_INT);
  wire irc_run = stop_mode ? (int_ref_out_enable && int_ref_stop_enable)
                           : int_needed;
  wire irc_rise = irc_run && !irc_ff && (irc_cnt_ff >= irc_half);

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irc_cnt_ff <= 10'h000;
      irc_ff <= 1'b0;
      irc_settle_ff <= 16'h0000;
      irc_stable_ff <= 1'b0;
    end else if (!irc_run) begin
      irc_cnt_ff <= 10'h000;
      irc_ff <= 1'b0;
      irc_settle_ff <= 16'h0000;
      irc_stable_ff <= 1'b0;
    end else begin
      if (irc_cnt_ff >= irc_half) begin
        irc_cnt_ff <= 10'h000;
        irc_ff <= !irc_ff;
      end else begin
        irc_cnt_ff <= irc_cnt_ff + 10'h001;
      end
      if (irc_settle_ff >= `IRC_SETTLE_CYC) begin
        irc_stable_ff <= 1'b1;
      end else begin
        irc_settle_ff <= irc_settle_ff + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // External reference
  // ----------------------------------------------------------------
  reg ext_s1_ff;
  reg ext_s2_ff;
  reg ext_d_ff;
  reg [15:0] osc_cnt_ff;
  wire ext_rise = ext_s2_ff && !ext_d_ff;
  wire ext_mode = (clock_source_select == `MODE_EXT) || !int_ref_select;
  wire ext_gate = !stop_mode || ext_ref_stop_enable;

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ext_s1_ff <= 1'b0;
      ext_s2_ff <= 1'b0;
      ext_d_ff <= 1'b0;
      osc_cnt_ff <= 16'h0000;
      osc_init_done <= 1'b0;
    end else begin
      ext_s1_ff <= ext_ref_in;
      ext_s2_ff <= ext_s1_ff;
      ext_d_ff <= ext_s2_ff;
      if (!ext_ref_out_enable || !ext_osc_select) begin
        osc_cnt_ff <= 16'h0000;
        osc_init_done <= 1'b0;
      end else if (osc_cnt_ff >= OSC_INIT_EDGES[15:0]) begin
        osc_init_done <= 1'b1;
      end else if (ext_rise && ext_mode) begin
        osc_cnt_ff <= osc_cnt_ff + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Gated reference outputs
  // ----------------------------------------------------------------
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      int_ref_clock_out <= 1'b0;
      ext_ref_clock_out <= 1'b0;
    end else begin
      int_ref_clock_out <= irc_ff && int_ref_out_enable
                           && irc_run;
      ext_ref_clock_out <= ext_s2_ff && ext_ref_out_enable
                           && ext_gate;
    end
  end

  // ----------------------------------------------------------------
  // FLL reference and fixed clock
  // ----------------------------------------------------------------
  reg [7:0] ref_cnt_ff;
  reg [3:0] lock_cnt_ff;
  reg prev_iref_ff;
  wire ref_tick = int_ref_select ? irc_rise : ext_rise;
  wire [7:0] ref_mask = (8'h01 << ref_divider_sel) - 8'h01;
  wire ff_tick = ref_tick && ((ref_cnt_ff & ref_mask) == ref_mask);
  wire bypass_sel = (clock_source_select != `MODE_FLL);

  assign fll_enable = !(fll_power_saver_bit && bypass_sel);

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ref_cnt_ff <= 8'h00;
      fixed_freq_clock <= 1'b0;
      lock_cnt_ff <= 4'h0;
      fll_locked <= 1'b0;
      prev_iref_ff <= 1'b1;
    end else begin
      prev_iref_ff <= int_ref_select;
      if (ref_tick) begin
        ref_cnt_ff <= ref_cnt_ff + 8'h01;
      end
      if (ff_tick) begin
        fixed_freq_clock <= !fixed_freq_clock;
      end
      if (!fll_enable || (prev_iref_ff != int_ref_select)) begin
        lock_cnt_ff <= 4'h0;
        fll_locked <= 1'b0;
      end else if (lock_cnt_ff >= `FLL_LOCK_REFS) begin
        fll_locked <= 1'b1;
      end else if (ff_tick && (!int_ref_select || irc_stable_ff)) begin
        lock_cnt_ff <= lock_cnt_ff + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Mode status switching
  // ----------------------------------------------------------------
  reg [2:0] sw_cnt_ff;
  reg [1:0] target_mode;
  reg target_tick;

  always @* begin
    target_mode = clock_mode_status;
    target_tick = 1'b0;
    case (clock_source_select)
      `MODE_FLL: begin
        target_mode = `MODE_FLL;
        target_tick = 1'b1;
      end
      `MODE_INT: begin
        target_mode = `MODE_INT;
        target_tick = irc_rise;
      end
      `MODE_EXT: begin
        target_mode = `MODE_EXT;
        target_tick = ext_rise;
      end
      default: begin
        target_mode = clock_mode_status;
        target_tick = 1'b0;
      end
    endcase
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      clock_mode_status <= `MODE_FLL;
      sw_cnt_ff <= 3'h0;
    end else if (target_mode == clock_mode_status) begin
      sw_cnt_ff <= 3'h0;
    end else if (target_tick) begin
      if (sw_cnt_ff >= `SWITCH_TICKS - 3'h1) begin
        clock_mode_status <= target_mode;
        sw_cnt_ff <= 3'h0;
      end else begin
        sw_cnt_ff <= sw_cnt_ff + 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Main clock with bus divider
  // ----------------------------------------------------------------
  reg [2:0] bus_divider_sel_cnt_ff;
  reg src_tick;
  wire [2:0] bus_divider_sel_lim = (3'h1 << bus_divider_sel) - 3'h1;

  always @* begin
    src_tick = 1'b0;
    case (clock_mode_status)
      `MODE_FLL: src_tick = !stop_mode;
      `MODE_INT: src_tick = irc_rise && !stop_mode;
      `MODE_EXT: src_tick = ext_rise && !stop_mode;
      default: src_tick = 1'b0;
    endcase
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bus_divider_sel_cnt_ff <= 3'h0;
      main_clock_out <= 1'b0;
    end else if (src_tick) begin
      if (bus_divider_sel_cnt_ff >= bus_divider_sel_lim) begin
        bus_divider_sel_cnt_ff <= 3'h0;
        main_clock_out <= !main_clock_out;
      end else begin
        bus_divider_sel_cnt_ff <= bus_divider_sel_cnt_ff + 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Fixed clock valid flag
  // ----------------------------------------------------------------
  wire [2:0] ffe_need = {1'b0, bus_divider_sel} + `FFE_OFFSET;
  assign fixed_freq_valid =
    (clock_mode_status == `MODE_FLL)
    || (ref_divider_sel >= ffe_need);

endmodule

`default_nettype wire

// ==== test/clock_source_output_control_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "clock_source_output_control_regs.vh"
module clock_source_output_control_asserts (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // System inputs
  input wire logic stop_mode,
  input wire logic ext_ref_in,
  // Clock outputs
  input wire logic main_clock_out,
  input wire logic int_ref_clock_out,
  input wire logic ext_ref_clock_out,
  input wire logic fixed_freq_clock,
  input wire logic fixed_freq_valid,
  input wire logic fll_enable,
  input wire logic fll_locked
);
  logic [7:0] one_ff;
  logic [7:0] two_ff;
  // ----------------------------------------
  // Control register shadows
  // ----------------------------------------
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      one_ff <= `CTRL_ONE_RST;
      two_ff <= `CTRL_TWO_RST;
    end else if (reg_wr && reg_addr == `CTRL_ONE_ADDR) begin
      one_ff <= reg_wdata;
    end else if (reg_wr && reg_addr == `CTRL_TWO_ADDR) begin
      two_ff <= reg_wdata;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  AST_FLL_OFF: assert property (
    fll_enable == !(two_ff[3] && one_ff[7:6] != 2'h0)) else $error("fll on");
  AST_LOCK_OFF: assert property (
    !fll_enable [*2] |-> !fll_locked) else $error("lock while off");
  AST_IRC_OFF: assert property (
    !one_ff[1] [*2] |-> !int_ref_clock_out) else $error("irc out");
  AST_ERC_OFF: assert property (
    !two_ff[1] [*3] |-> !ext_ref_clock_out) else $error("erc out");
  AST_IRC_STOP: assert property (
    (stop_mode && !one_ff[0]) [*2] |-> !int_ref_clock_out)
    else $error("irc in stop");
  AST_ERC_STOP: assert property (
    (stop_mode && !two_ff[0]) [*3] |-> !ext_ref_clock_out)
    else $error("erc in stop");
  AST_VALID_BYP: assert property (
    one_ff[5:3] >= {1'b0, two_ff[7:6]} + 3'h2 |-> fixed_freq_valid)
    else $error("valid low");
  AST_VALID_FLL: assert property (
    one_ff[7:6] == 2'h0 [*8] |-> fixed_freq_valid) else $error("valid fll");
  AST_MAIN_STOP: assert property (
    stop_mode [*2] |-> $stable(main_clock_out)) else $error("main in stop");
endmodule
`default_nettype wire

// ==== test/ext_ref_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module ext_ref_model #(
  parameter int HALF_NS = 100
) (
  // Reference pin
  output logic ref_clk
);
  // ----------------------------------------
  // Free-running source at 5 MHz
  // ----------------------------------------
  initial begin
    ref_clk = 1'b0;
    #3;
    forever #(HALF_NS) ref_clk = ~ref_clk;
  end
endmodule
`default_nettype wire

// ==== test/clock_source_output_control_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "clock_source_output_control_regs.vh"
module clock_source_output_control_tb;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic stop_mode = 1'b0;
  wire logic [7:0] reg_rdata;
  wire logic ext_ref_in, main_clock_out, int_ref_clock_out, ext_ref_clock_out;
  wire logic fixed_freq_clock, fixed_freq_valid, fll_enable, fll_locked;
  int n_errors = 0;
  int checks = 0;
  int cyc = 0;
  int e0, e1, b, r;
  logic [7:0] d;
  clock_source_output_control #(.OSC_INIT_EDGES(4)) DUT (
    .sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .stop_mode, .ext_ref_in, .main_clock_out, .int_ref_clock_out,
    .ext_ref_clock_out, .fixed_freq_clock, .fixed_freq_valid, .fll_enable,
    .fll_locked);
  ext_ref_model src (.ref_clk(ext_ref_in));
  always #5 sys_clk = ~sys_clk;
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      finish_test();
    end
  end
  task automatic chk(input string nm, input logic [7:0] x,
                     input logic [7:0] g);
    checks++;
    if (g !== x) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    v = reg_rdata;
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: return int_ref_clock_out;
      1: return ext_ref_clock_out;
      2: return main_clock_out;
      default: return fixed_freq_clock;
    endcase
  endfunction
  task automatic ed(input int s, input int n, output int e);
    logic p;
    e = 0;
    repeat (2) @(posedge sys_clk);
    p = pick(s);
    repeat (n) begin
      @(posedge sys_clk);
      if (pick(s) !== p) e++;
      p = pick(s);
    end
  endtask
  task automatic poll(input logic [7:0] m, input logic [7:0] x);
    logic [7:0] v;
    int k;
    k = 0;
    do begin
      repeat (20) @(posedge sys_clk);
      rd(`STATUS_ADDR, v);
      k++;
    end while ((v & m) !== x && k < 200);
    chk("status", x, v & m);
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rd(`CTRL_ONE_ADDR, d);
    chk("ctrl one", `CTRL_ONE_RST, d);
    rd(`CTRL_TWO_ADDR, d);
    chk("ctrl two", `CTRL_TWO_RST, d);
    rd(`TRIM_ADDR, d);
    chk("trim", `TRIM_POWERUP, d);
    chk("valid", 8'h01, fixed_freq_valid);
    rd(8'h10, d);
    chk("unmapped", 8'h00, d);
    wr(`TRIM_ADDR, 8'h5A);
    wr(`STATUS_ADDR, 8'h01);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rd(`TRIM_ADDR, d);
    chk("trim kept", 8'h5A, d);
    poll(8'hFF, 8'h01);
    $display("test reset done");
    wr(`CTRL_ONE_ADDR, 8'h46);
    poll(8'h0C, 8'h04);
    wr(`TRIM_ADDR, 8'h10);
    ed(0, 3000, e0);
    ed(2, 3000, b);
    wr(`TRIM_ADDR, 8'hF0);
    ed(0, 3000, e1);
    ed(2, 3000, r);
    chk("trim period", 8'h01, e0 > e1);
    chk("trim main", 8'h01, b > r);
    wr(`TRIM_ADDR, 8'h5A);
    wr(`CTRL_TWO_ADDR, 8'h00);
    ed(2, 2000, e0);
    wr(`CTRL_TWO_ADDR, 8'hC0);
    ed(2, 2000, e1);
    chk("bus div", 8'h01, e0 > e1);
    for (b = 0; b < 4; b++) begin
      for (r = 0; r < 8; r++) begin
        wr(`CTRL_TWO_ADDR, {b[1:0], 6'h00});
        wr(`CTRL_ONE_ADDR, 8'h46 | 8'(r << 3));
        chk("valid byp", r >= b + 2, fixed_freq_valid);
      end
    end
    wr(`CTRL_TWO_ADDR, 8'h48);
    chk("fll off", 8'h00, fll_enable);
    wr(`CTRL_TWO_ADDR, 8'h40);
    chk("fll on", 8'h01, fll_enable);
    wr(`CTRL_ONE_ADDR, 8'h04);
    poll(8'h0C, 8'h00);
    chk("valid fll", 8'h01, fixed_freq_valid);
    ed(3, 3000, e0);
    chk("fixed clk", 8'h01, e0 > 0);
    chk("fll locked", 8'h01, fll_locked);
    $display("test internal done");
    wr(`CTRL_TWO_ADDR, 8'h46);
    wr(`CTRL_ONE_ADDR, 8'h00);
    poll(8'h0E, 8'h02);
    ed(1, 200, e0);
    chk("erc on", 8'h01, e0 > 0);
    wr(`CTRL_ONE_ADDR, 8'h80);
    poll(8'h0C, 8'h08);
    chk("valid fbe", 8'h00, fixed_freq_valid);
    $display("test external done");
    wr(`CTRL_TWO_ADDR, 8'h47);
    wr(`CTRL_ONE_ADDR, 8'h02);
    stop_mode <= 1'b1;
    ed(0, 400, e0);
    chk("irc stop", 8'h00, e0);
    ed(1, 200, e1);
    chk("erc stop", 8'h01, e1 > 0);
    wr(`CTRL_ONE_ADDR, 8'h03);
    ed(0, 400, e0);
    chk("irc stop on", 8'h01, e0 > 0);
    wr(`CTRL_TWO_ADDR, 8'h46);
    ed(1, 200, e1);
    chk("erc stop off", 8'h00, e1);
    stop_mode <= 1'b0;
    $display("test stop done");
    wr(`CTRL_ONE_ADDR, 8'h04);
    poll(8'h0C, 8'h00);
    wr(`CTRL_TWO_ADDR, 8'h40);
    poll(8'h02, 8'h00);
    ed(1, 200, e0);
    chk("erc off", 8'h00, e0);
    $display("test return done");
    finish_test();
  end
endmodule
bind clock_source_output_control clock_source_output_control_asserts chk_i (
  .sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .stop_mode, .ext_ref_in, .main_clock_out, .int_ref_clock_out,
  .ext_ref_clock_out, .fixed_freq_clock, .fixed_freq_valid, .fll_enable,
  .fll_locked);
`default_nettype wire
